// ### design/sleep_pcu_pkg.sv
// constants and types shared by the sleep power sequencer
// assumes a 50 MHz power-unit clock and 8-bit control register numbers
package sleep_pcu_pkg;

    // processor control register numbers (index, not byte address)
    localparam logic [7:0] REG_WAKE_COUNTDOWN_LOAD   = 8'h08;
    localparam logic [7:0] REG_SLEEP_REQUEST_CONTROL = 8'h09;
    localparam int         ADDR_W                    = 8;
    localparam int         DATA_W                    = 32;

    // field positions and reset values
    localparam int          SLEEP_BIT_POS  = 0;
    localparam logic [31:0] COUNT_RESET    = 32'h0000_0000;
    localparam logic        SLEEP_BIT_RST  = 1'b0;
    localparam logic        GATE_DRIVE_LVL = 1'b0;

    // timing: wake pin minimum hold, rounded up to whole clock cycles
    localparam int WAKE_MIN_PS   = 100000;
    localparam int CLK_PERIOD_PS = 20000;
    localparam int WAKE_MIN_CYC_I =
        (WAKE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WAKE_MIN_CYC  = (WAKE_MIN_CYC_I < 1) ? 1 : WAKE_MIN_CYC_I;
    localparam int WAKE_CNT_W    = 4;
    localparam logic [WAKE_CNT_W-1:0] WAKE_MIN_CNT =
        WAKE_CNT_W'(WAKE_MIN_CYC);

    // sequencer states, one-hot
    typedef enum logic [2:0]
    {
        ST_ACTIVE   = 3'b001,
        ST_SLEEP    = 3'b010,
        ST_ENERGISE = 3'b100
    } pcu_state_e;

endpackage

// ### design/sleep_power_sequencer.sv
// power control unit: takes the core in and out of supply-gated sleep
// assumes the register write port comes from the local core on i_clk_sys,
// wake pin, oscillator and unit reset pin are asynchronous to it
`timescale 1ns/100ps

module sleep_power_sequencer
    import sleep_pcu_pkg::*;
#(
    parameter int CNT_W = 32
)
(
    // clock and reset
    input  wire logic              i_clk_sys,
    input  wire logic              i_nrst,
    // processor control register port
    input  wire logic              i_ps_wr,
    input  wire logic              i_ps_rd,
    input  wire logic              i_ps_local,
    input  wire logic [ADDR_W-1:0] i_ps_addr,
    input  wire logic [DATA_W-1:0] i_ps_wdata,
    output logic      [DATA_W-1:0] o_ps_rdata,
    // pins
    input  wire logic              i_wake_pin,
    input  wire logic              i_osc_clk,
    input  wire logic              i_power_unit_reset_n,
    // supply gate (open drain), core reset, decrement enable and state
    output logic                   o_vdd_gate_out,
    output logic                   o_vdd_gate_oe,
    output logic                   o_core_hold_reset_n,
    output logic                   o_dec_enable,
    output logic      [2:0]        o_state
);

    ////////////////////////////////////////////////////////////////////////
    // elaboration checks

    if (CNT_W < 1 || CNT_W > DATA_W)
    begin : g_bad_width
        $error("CNT_W must lie between 1 and the data width");
    end

    // the wake filter saturates at its minimum count, so that count
    // must be reachable in the filter counter or no pin wake is seen
    if (WAKE_MIN_CYC >= (1 << WAKE_CNT_W))
    begin : g_bad_filter
        $error("wake filter count does not fit its counter");
    end

    ////////////////////////////////////////////////////////////////////////
    // state of the whole unit
    //
    // everything the unit remembers lives in one record:
    // - synchroniser pairs for the sleep request, wake pin, unit reset
    //   and the oscillator, plus one extra oscillator flop for its edge
    // - the wake filter counter and the pending-wake latch
    // - the two software registers and the registered read data
    // - the registered copies of every output pin
    // keeping it in one place makes the reset value a single constant

    typedef struct packed
    {
        pcu_state_e            state;
        logic                  req_s1;
        logic                  req_s2;
        logic                  wake_s1;
        logic                  wake_s2;
        logic                  rst_s1;
        logic                  rst_s2;
        logic                  osc_s1;
        logic                  osc_s2;
        logic                  osc_s3;
        logic [WAKE_CNT_W-1:0] wake_cnt;
        logic                  wake_pend;
        logic                  sleep_bit;
        logic [CNT_W-1:0]      count;
        logic [DATA_W-1:0]     rdata;
        logic                  gate_out;
        logic                  gate_oe;
        logic                  core_rst_n;
        logic                  dec_en;
    } pcu_s;

    localparam pcu_s PCU_RESET = '{
        state:      ST_ACTIVE,
        req_s1:     1'b0,
        req_s2:     1'b0,
        wake_s1:    1'b0,
        wake_s2:    1'b0,
        rst_s1:     1'b1,
        rst_s2:     1'b1,
        osc_s1:     1'b0,
        osc_s2:     1'b0,
        osc_s3:     1'b0,
        wake_cnt:   '0,
        wake_pend:  1'b0,
        sleep_bit:  SLEEP_BIT_RST,
        count:      COUNT_RESET[CNT_W-1:0],
        rdata:      '0,
        gate_out:   GATE_DRIVE_LVL,
        gate_oe:    1'b0,
        core_rst_n: 1'b1,
        dec_en:     1'b0
    };

    pcu_s pcu_reg;
    pcu_s pcu_next;

    logic wr_ok;
    logic osc_tick;
    logic wake_ok;
    logic count_zero;
    logic unit_rst;

    ////////////////////////////////////////////////////////////////////////
    // next-state logic
    //
    // one pass computes the whole next record; helper flags below are
    // plain decodes of the current record and the write port, and never hold state
    // hazard: the wake pin, oscillator and unit reset pin are all
    // asynchronous, so nothing here reads them before their second flop

    always_comb
    begin
        pcu_next = pcu_reg;

        // synchronisers: first flop feeds only the second, except req_s1, which the wake latch clear also reads
        pcu_next.req_s1  = pcu_reg.sleep_bit;
        pcu_next.req_s2  = pcu_reg.req_s1;
        pcu_next.wake_s1 = i_wake_pin;
        pcu_next.wake_s2 = pcu_reg.wake_s1;
        pcu_next.rst_s1  = i_power_unit_reset_n;
        pcu_next.rst_s2  = pcu_reg.rst_s1;
        pcu_next.osc_s1  = i_osc_clk;
        pcu_next.osc_s2  = pcu_reg.osc_s1;
        pcu_next.osc_s3  = pcu_reg.osc_s2;

        unit_rst   = !pcu_reg.rst_s2;
        osc_tick   = pcu_reg.osc_s2 && !pcu_reg.osc_s3;
        count_zero = (pcu_reg.count == '0);

        // wake pin must stay high for the minimum hold before it counts
        // the counter saturates, so a long pin keeps wake_ok asserted;
        // a short glitch restarts it from zero and is ignored
        if (!pcu_reg.wake_s2)
            pcu_next.wake_cnt = '0;
        else if (pcu_reg.wake_cnt != WAKE_MIN_CNT)
            pcu_next.wake_cnt = pcu_reg.wake_cnt + 1'b1;
        wake_ok = (pcu_reg.wake_cnt == WAKE_MIN_CNT);

        // a wake seen while sleep is pending is held, so it is not lost
        // in the cycles the request spends crossing into the state
        // set wins over clear; the latch only drops once the unit is
        // energising or back to active with no request in flight
        if (wake_ok && (pcu_reg.sleep_bit || pcu_reg.req_s2
                        || pcu_reg.state == ST_SLEEP))
            pcu_next.wake_pend = 1'b1;
        else if (pcu_reg.state == ST_ENERGISE
                 || (pcu_reg.state == ST_ACTIVE && !pcu_reg.sleep_bit
                     && !pcu_reg.req_s1 && !pcu_reg.req_s2))
            pcu_next.wake_pend = 1'b0;

        // register writes: local core only, and only while it runs
        // writes from a core held in reset are dropped on purpose,
        // and the sleep bit is cleared there so a restart never
        // walks straight back into sleep
        wr_ok = i_ps_wr && i_ps_local && pcu_reg.core_rst_n;
        if (wr_ok && i_ps_addr == REG_SLEEP_REQUEST_CONTROL)
            pcu_next.sleep_bit = i_ps_wdata[SLEEP_BIT_POS];
        if (!pcu_reg.core_rst_n)
            pcu_next.sleep_bit = SLEEP_BIT_RST;

        // wake-up counter: load beats decrement, stops at zero
        // the count steps on synchronised oscillator rising edges only;
        // limitation: the oscillator must run below half the unit clock
        if (wr_ok && i_ps_addr == REG_WAKE_COUNTDOWN_LOAD)
            pcu_next.count = i_ps_wdata[CNT_W-1:0];
        else if (pcu_reg.dec_en && osc_tick && !count_zero)
            pcu_next.count = pcu_reg.count - 1'b1;

        // read port, registered
        // read data holds between reads, unmapped numbers read zero
        if (i_ps_rd && i_ps_addr == REG_WAKE_COUNTDOWN_LOAD)
            pcu_next.rdata = DATA_W'(pcu_reg.count);
        else if (i_ps_rd && i_ps_addr == REG_SLEEP_REQUEST_CONTROL)
            pcu_next.rdata = DATA_W'(pcu_reg.sleep_bit);
        else if (i_ps_rd)
            pcu_next.rdata = '0;

        // sequencer; unit reset forces active from any state
        // a counter already at zero wakes the unit on its first cycle
        // asleep; energise is left only through the unit reset pin,
        // so the core always restarts from power-on reset
        case (pcu_reg.state)
            ST_ACTIVE:
            begin
                if (!unit_rst && pcu_reg.req_s2)
                    pcu_next.state = ST_SLEEP;
            end
            ST_SLEEP:
            begin
                if (unit_rst)
                    pcu_next.state = ST_ACTIVE;
                else if (wake_ok || pcu_reg.wake_pend || count_zero)
                    pcu_next.state = ST_ENERGISE;
            end
            ST_ENERGISE:
            begin
                // only a power-on reset releases the core again
                if (unit_rst)
                    pcu_next.state = ST_ACTIVE;
            end
            default:
                pcu_next.state = ST_ACTIVE;
        endcase

        // outputs decoded from next state, so every pin is a flop
        // and changes on the same edge as the state itself; the gate
        // level is always low, only its enable decides the pin
        pcu_next.gate_out = GATE_DRIVE_LVL;
        case (pcu_next.state)
            ST_SLEEP:
            begin
                pcu_next.gate_oe    = 1'b1;
                pcu_next.dec_en     = 1'b1;
                pcu_next.core_rst_n = 1'b0;
            end
            ST_ENERGISE:
            begin
                pcu_next.gate_oe    = 1'b0;
                pcu_next.dec_en     = 1'b0;
                pcu_next.core_rst_n = 1'b0;
            end
            default:
            begin
                pcu_next.gate_oe    = 1'b0;
                pcu_next.dec_en     = 1'b0;
                pcu_next.core_rst_n = 1'b1;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    // asynchronous reset loads only the constant reset record

    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            pcu_reg <= PCU_RESET;
        else
            pcu_reg <= pcu_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    // each pin is a straight copy of a registered field, no logic

    assign o_ps_rdata          = pcu_reg.rdata;
    assign o_vdd_gate_out      = pcu_reg.gate_out;
    assign o_vdd_gate_oe       = pcu_reg.gate_oe;
    assign o_core_hold_reset_n = pcu_reg.core_rst_n;
    assign o_dec_enable        = pcu_reg.dec_en;
    assign o_state             = pcu_reg.state;

endmodule

// ### verif/sleep_power_sequencer_properties.sv
// port checker for the sleep power sequencer
// assumes binding onto sleep_power_sequencer, a single clock domain
`timescale 1ns/100ps
module sleep_power_sequencer_properties
    import sleep_pcu_pkg::*;
#(
    parameter int CNT_W = 32
)
(
    // clock, reset and inputs
    input wire logic              i_clk_sys,
    input wire logic              i_nrst,
    input wire logic              i_ps_wr,
    input wire logic              i_ps_local,
    input wire logic [ADDR_W-1:0] i_ps_addr,
    input wire logic [DATA_W-1:0] i_ps_wdata,
    input wire logic              i_wake_pin,
    input wire logic              i_power_unit_reset_n,
    // sequencer outputs
    input wire logic              o_vdd_gate_out,
    input wire logic              o_vdd_gate_oe,
    input wire logic              o_core_hold_reset_n,
    input wire logic              o_dec_enable,
    input wire logic [2:0]        o_state
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    ////////////////////////////////////////////////////////////////////
    // state decode; go_sleep only counts writes the core may make
    logic go_sleep;
    logic asleep;
    logic energ;
    assign go_sleep = i_ps_wr && i_ps_local && o_core_hold_reset_n
        && i_ps_wdata[SLEEP_BIT_POS] && i_ps_addr == REG_SLEEP_REQUEST_CONTROL;
    assign asleep = o_state == ST_SLEEP;
    assign energ = o_state == ST_ENERGISE;
    // outputs of each state
    sleep_outs_a: assert property (asleep |-> o_vdd_gate_oe &&
        o_dec_enable && !o_core_hold_reset_n) else $error("sleep outputs");
    energ_outs_a: assert property (energ |-> !o_vdd_gate_oe &&
        !o_dec_enable && !o_core_hold_reset_n) else $error("energise outs");
    active_outs_a: assert property (o_state == ST_ACTIVE |->
        !o_vdd_gate_oe && !o_dec_enable && o_core_hold_reset_n)
        else $error("active outputs");
    gate_low_a: assert property (o_vdd_gate_oe |-> !o_vdd_gate_out)
        else $error("gate driven high");
    // entry to sleep: register write, two sync flops plus one state step
    sleep_entry_a: assert property (go_sleep
        && i_power_unit_reset_n && o_state == ST_ACTIVE |-> ##4 asleep)
        else $error("late sleep");
    sleep_cause_a: assert property ($rose(asleep) |->
        $past(go_sleep, 4)) else $error("sleep without request");
    wake_pin_a: assert property (i_wake_pin && asleep ##1
        i_wake_pin [*7] |-> ##[1:2] energ) else $error("wake pin missed");
    energ_hold_a: assert property (
        i_power_unit_reset_n [*3] ##0 energ |=> energ)
        else $error("energise left early");
    unit_reset_a: assert property (!i_power_unit_reset_n [*3]
        |=> o_state == ST_ACTIVE) else $error("unit reset ignored");
    // main scenarios reached
    sleep_c: cover property ($rose(asleep));
    energ_c: cover property ($rose(energ));
    back_c: cover property (energ ##1 o_state == ST_ACTIVE);
endmodule
bind sleep_power_sequencer sleep_power_sequencer_properties #(.CNT_W(CNT_W))
    i_sleep_power_sequencer_properties (.i_clk_sys, .i_nrst, .i_ps_wr,
    .i_ps_local, .i_ps_addr, .i_ps_wdata, .i_wake_pin, .i_power_unit_reset_n,
    .o_vdd_gate_out, .o_vdd_gate_oe, .o_core_hold_reset_n, .o_dec_enable,
    .o_state);

// ### verif/sleep_power_sequencer_tb_top.sv
// self-checking bench for the sleep power sequencer
// assumes the wake source model and the bound property checker
`timescale 1ns/100ps
module sleep_power_sequencer_tb_top;
    import sleep_pcu_pkg::*;
    logic        clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, loc = 1'b1;
    logic        unit_n = 1'b1, osc_run = 1'b0, wake_go = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wake_len = 4'h0;
    logic        wake, osc, g_out, g_oe, core_n, pwr, dec;
    logic [2:0]  state;
    int          n_fail = 0, total_checks = 0;
    ////////////////////////////////////////////////////////////////////
    // design and far side
    sleep_power_sequencer i_sleep_power_sequencer (.i_clk_sys(clk),
        .i_nrst(nrst), .i_ps_wr(wr), .i_ps_rd(rd), .i_ps_local(loc),
        .i_ps_addr(addr), .i_ps_wdata(wdata), .o_ps_rdata(rdata),
        .i_wake_pin(wake), .i_osc_clk(osc), .i_power_unit_reset_n(unit_n),
        .o_vdd_gate_out(g_out), .o_vdd_gate_oe(g_oe),
        .o_core_hold_reset_n(core_n), .o_dec_enable(dec), .o_state(state));
    wake_source_model i_wake_source_model (.i_clk_sys(clk),
        .i_osc_run(osc_run), .i_wake_go(wake_go), .i_wake_len(wake_len),
        .i_vdd_gate_out(g_out), .i_vdd_gate_oe(g_oe), .o_wake_pin(wake),
        .o_osc_clk(osc), .o_core_pwr(pwr));
    // clock and watchdog, generous against a few hundred cycles of tests
    initial forever #10 clk = ~clk;
    initial
    begin
        repeat (3000) @(posedge clk);
        n_fail++;
        report_and_stop();
    end
    // comparison, access and sequencing tasks
    task automatic chk(input logic [31:0] seen, exp, input string nm);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d,
        input logic l);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        loc <= l;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e, "rdata");
    endtask
    task automatic wait_st(input logic [2:0] e, input int n);
        repeat (n) if (state !== e) @(posedge clk);
        #1 chk({29'h0, state}, {29'h0, e}, "state");
    endtask
    task automatic pulse(input logic [3:0] n);
        @(posedge clk);
        wake_go <= 1'b1;
        wake_len <= n;
        @(posedge clk);
        wake_go <= 1'b0;
    endtask
    // unit reset pin low for three samples brings the unit back
    task automatic recover();
        @(posedge clk);
        unit_n <= 1'b0;
        repeat (3) @(posedge clk);
        unit_n <= 1'b1;
        wait_st(ST_ACTIVE, 6);
    endtask
    task automatic report_and_stop();
        if (n_fail == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // tests: registers, pin wake, counter wake, coincident wake
    initial
    begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rd_chk(8'h10, 32'h0);
        rd_chk(REG_SLEEP_REQUEST_CONTROL, 32'h0);
        wr_reg(REG_WAKE_COUNTDOWN_LOAD, 32'h1234_5678, 1'b0);
        rd_chk(REG_WAKE_COUNTDOWN_LOAD, COUNT_RESET);
        wr_reg(REG_WAKE_COUNTDOWN_LOAD, 32'h0000_0100, 1'b1);
        rd_chk(REG_WAKE_COUNTDOWN_LOAD, 32'h0000_0100);
        wr_reg(REG_SLEEP_REQUEST_CONTROL, 32'h1, 1'b0);
        wr_reg(REG_SLEEP_REQUEST_CONTROL, 32'hffff_fffe, 1'b1);
        repeat (8) @(posedge clk);
        wait_st(ST_ACTIVE, 0);
        wr_reg(REG_SLEEP_REQUEST_CONTROL, 32'h1, 1'b1);
        wait_st(ST_SLEEP, 6);
        chk({31'h0, pwr}, 32'h0, "core_power");
        chk({31'h0, dec}, 32'h1, "dec_enable");
        pulse(4'h3);
        repeat (12) @(posedge clk);
        wait_st(ST_SLEEP, 0);
        wr_reg(REG_WAKE_COUNTDOWN_LOAD, 32'h5, 1'b1);
        pulse(4'h8);
        wait_st(ST_ENERGISE, 12);
        chk({30'h0, core_n, pwr}, 32'h1, "reset_power");
        recover();
        rd_chk(REG_SLEEP_REQUEST_CONTROL, 32'h0);
        rd_chk(REG_WAKE_COUNTDOWN_LOAD, 32'h0000_0100);
        wr_reg(REG_WAKE_COUNTDOWN_LOAD, 32'h3, 1'b1);
        osc_run <= 1'b1;
        wr_reg(REG_SLEEP_REQUEST_CONTROL, 32'h1, 1'b1);
        wait_st(ST_ENERGISE, 80);
        recover();
        rd_chk(REG_WAKE_COUNTDOWN_LOAD, 32'h0);
        osc_run <= 1'b0;
        wr_reg(REG_WAKE_COUNTDOWN_LOAD, 32'hffff_ffff, 1'b1);
        rd_chk(REG_SLEEP_REQUEST_CONTROL, 32'h0);
        // wake filter fires while the request is still crossing
        pulse(4'h6);
        repeat (4) @(posedge clk);
        wr_reg(REG_SLEEP_REQUEST_CONTROL, 32'h1, 1'b1);
        wait_st(ST_ENERGISE, 30);
        recover();
        report_and_stop();
    end
endmodule

// ### verif/wake_source_model.sv
// external wake source, oscillator and supply gate transistor
// assumes the bench clock; pins change just after its rising edge
`timescale 1ns/100ps
module wake_source_model
(
    // bench control
    input  wire logic       i_clk_sys,
    input  wire logic       i_osc_run,
    input  wire logic       i_wake_go,
    input  wire logic [3:0] i_wake_len,
    // sequencer pins
    input  wire logic       i_vdd_gate_out,
    input  wire logic       i_vdd_gate_oe,
    output logic            o_wake_pin,
    output logic            o_osc_clk,
    output logic            o_core_pwr
);
    logic [3:0] wake_cnt = 4'h0;
    logic [1:0] osc_div  = 2'h0;
    ////////////////////////////////////////////////////////////////////
    // pin held exactly the commanded cycles, short ones too
    always_ff @(posedge i_clk_sys)
    begin
        wake_cnt <= i_wake_go ? i_wake_len : wake_cnt - 4'(wake_cnt != 4'h0);
        osc_div  <= osc_div + 2'h1;
    end
    assign o_wake_pin = wake_cnt != 4'h0;
    // slow oscillator, stands low when stopped
    assign o_osc_clk = i_osc_run & osc_div[1];
    // gate line pulled up when floated; low removes core power
    assign o_core_pwr = i_vdd_gate_oe ? i_vdd_gate_out : 1'b1;
endmodule
